// ===== hw/cis_core.sv
// interrupt latch, nesting, idle and status-push masking logic
//
// Implementation choices: register access over AXI4-Lite and the address map.
`include "cis_cfg.svh"

// Operation
// - ci jump clears latch, pointer; pops status
// - ci jump stops per-cycle latch clearing
// - without ci jump, repeat interrupt dropped
// - idle fetches one more, then suspends
// - clock and enabled timer run in idle
// - interrupt releases idle; vector after five cycles
// - idle leaves dma running
// - delayed interrupts still latched, processed later
// - defer first cycle of pm conflict
// - defer on dma or wait-state stall
// - defer branch and two following cycles
// - defer first four cycles of entry
// - defer arithmetic loop abort plus three
// - defer counted loop expiry cases
// - status push clears masked mode bits
// - push on instruction, irq or timer
// - only bits set in both change
// - mode mask default disables simd
// - nesting bit enables nesting
// - higher priority preempts when nesting
// - mask pointer gives temporary mask
// - no preemption when nesting disabled
// - priority 0 highest to 41 lowest
// - active routine latch cleared each cycle
// - temporary mask blocks equal or lower
// - return clears top pointer bit
module cis_core (
   input  wire logic                  aclk,          // core clock
   input  wire logic                  aresetn,       // sync reset, low
   input  wire logic [`CIS_NIRQ-1:0]  irq_in,        // interrupt events
   input  wire logic [1:0]            ext_src,       // 0 external request, 1 timer
   input  wire cis_pkg::cis_pipe_s    pipe,          // pipeline events
   output logic                       isr_start,     // vector fetch pulse
   output logic [`CIS_IDX_W-1:0]      isr_vector,    // serviced index
   output logic                       core_halted,   // idle state
   output logic                       timer_tick_en, // timer running
   output logic                       dma_enable,    // io processor run
   output logic                       sts_pop,       // status pop pulse
   input  wire logic [31:0]           s_axi_awaddr,  // axi write address
   input  wire logic                  s_axi_awvalid, // axi
   output logic                       s_axi_awready, // axi
   input  wire logic [31:0]           s_axi_wdata,   // axi
   input  wire logic [3:0]            s_axi_wstrb,   // axi
   input  wire logic                  s_axi_wvalid,  // axi
   output logic                       s_axi_wready,  // axi
   output logic [1:0]                 s_axi_bresp,   // axi
   output logic                       s_axi_bvalid,  // axi
   input  wire logic                  s_axi_bready,  // axi
   input  wire logic [31:0]           s_axi_araddr,  // axi
   input  wire logic                  s_axi_arvalid, // axi
   output logic                       s_axi_arready, // axi
   output logic [31:0]                s_axi_rdata,   // axi
   output logic [1:0]                 s_axi_rresp,   // axi
   output logic                       s_axi_rvalid,  // axi
   input  wire logic                  s_axi_rready   // axi
);
   localparam int N = `CIS_NIRQ;

   // ************************************************
   // helpers
   // ************************************************
   // lowest set index is highest priority
   function automatic logic [N-1:0] top_bit(input logic [N-1:0] v);
      logic [N-1:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = '0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction

   function automatic logic [`CIS_IDX_W-1:0] enc(input logic [N-1:0] v);
      logic [`CIS_IDX_W-1:0] r;
      r = '0;
      for (int i = 0; i < N; i++) begin
         if (v[i]) begin
            r = i[`CIS_IDX_W-1:0];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // indices that push status on entry
   function automatic logic [N-1:0] irq_mask_push(input logic [1:0] src);
      logic [N-1:0] r;
      r = '0;
      r[8:6] = {3{src[0]}};
      r[4]   = src[1];
      return r;
   endfunction

   // ************************************************
   // state
   // ************************************************
   logic [N-1:0]  latch_reg, latch_next;
   logic [N-1:0]  interrupt_mask_register_reg, interrupt_mask_register_next;
   logic [N-1:0]  ptr_reg, ptr_next;
   logic [N-1:0]  active_reg, active_next;
   logic [31:0]   mode_reg, mode_next;
   logic [31:0]   mode_mask_register_reg, mode_mask_register_next;
   logic [`CIS_HOLD_W-1:0] hold_reg, hold_next;
   logic [`CIS_HOLD_W-1:0] wake_reg, wake_next;
   logic          pmc_reg, pmc_next;
   cis_pkg::cis_state_e st_reg, st_next;
   logic          start_reg, start_next;
   logic [`CIS_IDX_W-1:0] vec_reg, vec_next;
   logic          pop_reg, pop_next;
   logic          halt_reg, halt_next;
   logic          tmr_reg, tmr_next;
   logic          wr_go;
   logic [7:0]    wr_addr;
   logic          aresetn_q;

   logic [N-1:0]  tmp_mask, eligible, winner, ptr_top;
   logic          defer, nest_en;

   // ************************************************
   // priority and deferral
   // ************************************************
   always_comb begin
      nest_en  = mode_reg[`CIS_NESTING_ENABLE_BIT_BIT];
      ptr_top  = top_bit(ptr_reg);
      tmp_mask = interrupt_mask_register_reg;
      if (ptr_reg != '0) begin
         if (nest_en) begin
            tmp_mask = interrupt_mask_register_reg & (ptr_top - {{(N-1){1'b0}}, 1'b1});
         end else begin
            tmp_mask = '0;
         end
      end
      eligible = latch_reg & tmp_mask;
      winner   = top_bit(eligible);
      defer    = (hold_reg != '0) || (pipe.pm_conflict && !pmc_reg)
               || pipe.dma_stall || pipe.ws_stall
               || pipe.branch || pipe.ar_loop_abort
               || pipe.cnt_expired || pipe.cnt_do_exec;
   end

   // ************************************************
   // sequencing
   // ************************************************
   always_comb begin
      logic [31:0] wtmp;
      logic [`CIS_HOLD_W-1:0] h;
      logic push;
      wtmp        = '0;
      h           = '0;
      push        = 1'b0;
      latch_next  = latch_reg | (irq_in & ~active_reg);
      interrupt_mask_register_next  = interrupt_mask_register_reg;
      ptr_next    = ptr_reg;
      active_next = active_reg;
      mode_next   = mode_reg;
      mode_mask_register_next  = mode_mask_register_reg;
      pmc_next    = pipe.pm_conflict && !pmc_reg;
      st_next     = st_reg;
      start_next  = 1'b0;
      vec_next    = vec_reg;
      pop_next    = 1'b0;
      wake_next   = wake_reg;
      hold_next   = (hold_reg != '0) ? hold_reg - 1'b1 : '0;
      if (pipe.branch) begin
         h = `CIS_HOLD_W'(`CIS_BRANCH_HOLD);
      end
      if (pipe.ar_loop_abort) begin
         h = `CIS_HOLD_W'(`CIS_AR_LOOP_HOLD);
      end
      if (pipe.cnt_expired) begin
         h = `CIS_HOLD_W'(`CIS_CNT_LOOP_HOLD);
      end
      if (pipe.cnt_do_exec && h < `CIS_CNT_DO_HOLD) begin
         h = `CIS_HOLD_W'(`CIS_CNT_DO_HOLD);
      end
      if (h > hold_next) begin
         hold_next = h;
      end
      // clear-interrupt jump turns the routine into a subroutine
      if (pipe.ci_jump && ptr_reg != '0) begin
         latch_next  = latch_next & ~ptr_top;
         ptr_next    = ptr_reg & ~ptr_top;
         active_next = active_reg & ~ptr_top;
         pop_next    = 1'b1;
      end else if (pipe.return_from_interrupt && ptr_reg != '0) begin
         ptr_next    = ptr_reg & ~ptr_top;
         active_next = active_reg & ~ptr_top;
      end
      push = pipe.status_push_instruction;
      case (st_reg)
         cis_pkg::ST_RUN: begin
            if (pipe.idle) begin
               st_next = cis_pkg::ST_IDLE_FETCH;
            end else if (eligible != '0 && !defer) begin
               start_next  = 1'b1;
               vec_next    = enc(winner);
               latch_next  = latch_next & ~winner;
               ptr_next    = ptr_next | winner;
               active_next = active_next | winner;
               hold_next   = `CIS_HOLD_W'(`CIS_ENTRY_HOLD);
               if ((winner & irq_mask_push(ext_src)) != '0) begin
                  push = 1'b1;
               end
            end
         end
         cis_pkg::ST_IDLE_FETCH: begin
            st_next = cis_pkg::ST_IDLE;
         end
         cis_pkg::ST_IDLE: begin
            if (eligible != '0) begin
               st_next   = cis_pkg::ST_WAKE;
               wake_next = `CIS_HOLD_W'(`CIS_ISR_LAT_CYC - 1);
            end
         end
         cis_pkg::ST_WAKE: begin
            if (wake_reg != '0) begin
               wake_next = wake_reg - 1'b1;
            end else begin
               st_next = cis_pkg::ST_RUN;
            end
         end
         default: begin
            st_next = cis_pkg::ST_RUN;
         end
      endcase
      if (push) begin
         mode_next = mode_next & ~mode_mask_register_reg;
      end
      // register writes
      if (wr_go) begin
         case (wr_addr)
            `CIS_A_LATCH_LO: latch_next[31:0]  = merge(latch_reg[31:0], wd_reg, ws_reg);
            `CIS_A_LATCH_HI: begin
               wtmp = merge({22'h0, latch_reg[N-1:32]}, wd_reg, ws_reg);
               latch_next[N-1:32] = wtmp[N-33:0];
            end
            `CIS_A_MASK_LO:  interrupt_mask_register_next[31:0]  = merge(interrupt_mask_register_reg[31:0], wd_reg, ws_reg);
            `CIS_A_MASK_HI:  begin
               wtmp = merge({22'h0, interrupt_mask_register_reg[N-1:32]}, wd_reg, ws_reg);
               interrupt_mask_register_next[N-1:32] = wtmp[N-33:0];
            end
            `CIS_A_MODE:     mode_next  = merge(mode_reg, wd_reg, ws_reg);
            `CIS_A_MODE_MASK_REGISTER:    mode_mask_register_next = merge(mode_mask_register_reg, wd_reg, ws_reg);
            default: begin
            end
         endcase
         latch_next = latch_next | (irq_in & ~active_reg);
      end
      halt_next = (st_next == cis_pkg::ST_IDLE) || (st_next == cis_pkg::ST_WAKE);
      tmr_next  = pipe.timer_en;
   end

   // ************************************************
   // axi4-lite slave
   // ************************************************
   logic         aw_reg, aw_next, w_reg, w_next, b_reg, b_next, bslv_reg, bslv_next;
   logic [7:0]   awa_reg, awa_next;
   logic [31:0]  wd_reg, wd_next;
   logic [3:0]   ws_reg, ws_next;
   logic         r_reg, r_next, rslv_reg, rslv_next;
   logic [31:0]  rd_reg, rd_next;
   logic         awrdy_reg, awrdy_next, wrdy_reg, wrdy_next, ardy_reg, ardy_next;

   always_comb begin
      aw_next  = aw_reg;
      w_next   = w_reg;
      awa_next = awa_reg;
      wd_next  = wd_reg;
      ws_next  = ws_reg;
      b_next   = b_reg;
      bslv_next = bslv_reg;
      if (!aw_reg && s_axi_awvalid && !b_reg) begin
         aw_next  = 1'b1;
         awa_next = s_axi_awaddr[7:0];
      end
      if (!w_reg && s_axi_wvalid && !b_reg) begin
         w_next  = 1'b1;
         wd_next = s_axi_wdata;
         ws_next = s_axi_wstrb;
      end
      wr_go   = aw_reg && w_reg;
      wr_addr = awa_reg;
      if (wr_go) begin
         aw_next   = 1'b0;
         w_next    = 1'b0;
         b_next    = 1'b1;
         bslv_next = wr_addr > `CIS_A_STATUS || wr_addr[1:0] != 2'h0;
      end
      if (b_reg && s_axi_bready) begin
         b_next = 1'b0;
      end
      r_next    = r_reg;
      rslv_next = rslv_reg;
      rd_next   = rd_reg;
      if (r_reg && s_axi_rready) begin
         r_next = 1'b0;
      end else if (!r_reg && s_axi_arvalid) begin
         r_next    = 1'b1;
         rslv_next = 1'b0;
         case (s_axi_araddr[7:0])
            `CIS_A_LATCH_LO: rd_next = latch_reg[31:0];
            `CIS_A_LATCH_HI: rd_next = {22'h0, latch_reg[N-1:32]};
            `CIS_A_MASK_LO:  rd_next = interrupt_mask_register_reg[31:0];
            `CIS_A_MASK_HI:  rd_next = {22'h0, interrupt_mask_register_reg[N-1:32]};
            `CIS_A_PTR_LO:   rd_next = ptr_reg[31:0];
            `CIS_A_PTR_HI:   rd_next = {22'h0, ptr_reg[N-1:32]};
            `CIS_A_MODE:     rd_next = mode_reg;
            `CIS_A_MODE_MASK_REGISTER:    rd_next = mode_mask_register_reg;
            `CIS_A_STATUS:   rd_next = {24'h0, halt_reg, 1'b0, vec_reg};
            default: begin
               rd_next   = 32'h0000_0000;
               rslv_next = 1'b1;
            end
         endcase
      end
      // readies registered from the next buffer state
      awrdy_next = !aw_next && !b_next;
      wrdy_next  = !w_next && !b_next;
      ardy_next  = !r_next;
   end

   // ************************************************
   // registers
   // ************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_reg <= '0; interrupt_mask_register_reg <= '0; ptr_reg <= '0; active_reg <= '0;
         mode_reg <= '0; mode_mask_register_reg <= `CIS_MODE_MASK_REGISTER_RST; hold_reg <= '0; wake_reg <= '0;
         pmc_reg <= 1'b0; st_reg <= cis_pkg::ST_RUN; start_reg <= 1'b0; vec_reg <= '0;
         pop_reg <= 1'b0; halt_reg <= 1'b0; tmr_reg <= 1'b0;
         aw_reg <= 1'b0; w_reg <= 1'b0; b_reg <= 1'b0; bslv_reg <= 1'b0; awa_reg <= '0;
         wd_reg <= '0; ws_reg <= '0; r_reg <= 1'b0; rslv_reg <= 1'b0; rd_reg <= '0;
         awrdy_reg <= 1'b1; wrdy_reg <= 1'b1; ardy_reg <= 1'b1;
      end else begin
         latch_reg <= latch_next; interrupt_mask_register_reg <= interrupt_mask_register_next; ptr_reg <= ptr_next;
         active_reg <= active_next; mode_reg <= mode_next; mode_mask_register_reg <= mode_mask_register_next;
         hold_reg <= hold_next; wake_reg <= wake_next; pmc_reg <= pmc_next;
         st_reg <= st_next; start_reg <= start_next; vec_reg <= vec_next;
         pop_reg <= pop_next; halt_reg <= halt_next; tmr_reg <= tmr_next;
         aw_reg <= aw_next; w_reg <= w_next; b_reg <= b_next; bslv_reg <= bslv_next;
         awa_reg <= awa_next; wd_reg <= wd_next; ws_reg <= ws_next;
         r_reg <= r_next; rslv_reg <= rslv_next; rd_reg <= rd_next;
         awrdy_reg <= awrdy_next; wrdy_reg <= wrdy_next; ardy_reg <= ardy_next;
      end
   end

   assign isr_start     = start_reg;
   assign isr_vector    = vec_reg;
   assign core_halted   = halt_reg;
   assign timer_tick_en = tmr_reg;
   assign dma_enable    = aresetn_q;
   assign sts_pop       = pop_reg;
   assign s_axi_awready = awrdy_reg;
   assign s_axi_wready  = wrdy_reg;
   assign s_axi_bvalid  = b_reg;
   assign s_axi_bresp   = bslv_reg ? 2'h2 : 2'h0;
   assign s_axi_arready = ardy_reg;
   assign s_axi_rvalid  = r_reg;
   assign s_axi_rdata   = rd_reg;
   assign s_axi_rresp   = rslv_reg ? 2'h2 : 2'h0;

   always_ff @(posedge aclk) begin
      aresetn_q <= aresetn;
   end
endmodule // cis_core

// ===== include/cis_cfg.svh
// constants for the core interrupt sequencing block
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH
`define CIS_NIRQ            42
`define CIS_IDX_W           6
`define CIS_MODE_W          32
`define CIS_NESTING_ENABLE_BIT_BIT       11
`define CIS_SIMD_BIT        21
`define CIS_MODE_MASK_REGISTER_RST       32'h0020_0000
`define CIS_ISR_LAT_NS      200
`define CIS_CLK_NS          40
`define CIS_ISR_LAT_CYC     ((`CIS_ISR_LAT_NS) / (`CIS_CLK_NS))
`define CIS_BRANCH_HOLD     2
`define CIS_AR_LOOP_HOLD    3
`define CIS_CNT_LOOP_HOLD   3
`define CIS_CNT_DO_HOLD     1
`define CIS_ENTRY_HOLD      4
`define CIS_HOLD_W          3
// register byte addresses
`define CIS_A_LATCH_LO      8'h00
`define CIS_A_LATCH_HI      8'h04
`define CIS_A_MASK_LO       8'h08
`define CIS_A_MASK_HI       8'h0C
`define CIS_A_PTR_LO        8'h10
`define CIS_A_PTR_HI        8'h14
`define CIS_A_MODE          8'h18
`define CIS_A_MODE_MASK_REGISTER         8'h1C
`define CIS_A_STATUS        8'h20
`endif

// ===== include/cis_pkg.sv
// types for the core interrupt sequencing block
`include "cis_cfg.svh"
package cis_pkg;
   typedef logic [`CIS_NIRQ-1:0] cis_vec_t;
   typedef enum logic [1:0] {ST_RUN, ST_IDLE_FETCH, ST_IDLE, ST_WAKE} cis_state_e;
   typedef struct packed {
      logic ci_jump;
      logic return_from_interrupt;
      logic status_push_instruction;
      logic idle;
      logic branch;
      logic pm_conflict;
      logic dma_stall;
      logic ws_stall;
      logic ar_loop_abort;
      logic cnt_expired;
      logic cnt_do_exec;
      logic timer_en;
   } cis_pipe_s;
endpackage

// ===== verif/cis_far_model.sv
// far-side model: interrupt sources and pipeline events
`include "cis_cfg.svh"
module cis_far_model (
   input  wire logic                 aclk,     // core clock
   input  wire logic                 aresetn,  // sync reset, low
   input  wire logic [`CIS_NIRQ-1:0] fire_vec, // events to raise
   input  wire cis_pkg::cis_pipe_s   pipe_req, // events to issue
   output logic [`CIS_NIRQ-1:0]      irq_in,   // interrupt lines
   output cis_pkg::cis_pipe_s        pipe      // pipeline events
);
   timeunit 1ns;
   timeprecision 1ps;
   // sources and events follow the requests one cycle later; zero in reset
   always_ff @(posedge aclk) begin
      irq_in <= aresetn ? fire_vec : '0;
      pipe   <= aresetn ? pipe_req : '0;
   end
endmodule // cis_far_model

// ===== verif/cis_core_asserts.sv
// port checker for the core interrupt sequencing block
`include "cis_cfg.svh"
module cis_core_asserts (
   input wire logic                 aclk,          // core clock
   input wire logic                 aresetn,       // sync reset, low
   input wire logic [`CIS_NIRQ-1:0] irq_in,        // interrupt events
   input wire cis_pkg::cis_pipe_s   pipe,          // pipeline events
   input wire logic                 isr_start,     // routine start
   input wire logic                 core_halted,   // idle state
   input wire logic                 timer_tick_en, // timer running
   input wire logic                 dma_enable,    // io processor run
   input wire logic                 sts_pop        // status pop
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence quiet3; !isr_start [*3]; endsequence
   sequence quiet4; !isr_start [*4]; endsequence
   sequence idle_calm; pipe.idle ##1 (irq_in == '0) [*4]; endsequence
   entry_hold_a: assert property (isr_start |=> quiet3) else $error("restart in entry");
   branch_defer_a: assert property (pipe.branch |=> quiet3) else $error("start after branch");
   arloop_defer_a: assert property (pipe.ar_loop_abort |=> quiet4) else $error("start after abort");
   cntloop_defer_a: assert property (pipe.cnt_expired |=> quiet4) else $error("start after expiry");
   stall_defer_a: assert property (pipe.dma_stall || pipe.ws_stall |=> !isr_start) else $error("start in stall");
   pm_defer_a: assert property ($rose(pipe.pm_conflict) |=> !isr_start) else $error("start in conflict");
   dma_run_a: assert property ($past(aresetn) |-> dma_enable) else $error("dma halted");
   timer_follow_a: assert property ($past(aresetn) |-> timer_tick_en == $past(pipe.timer_en))
      else $error("timer not following");
   pop_cause_a: assert property ($rose(sts_pop) |-> pipe.ci_jump || $past(pipe.ci_jump))
      else $error("pop without jump");
   idle_halt_a: assert property (idle_calm |-> core_halted) else $error("idle not halted");
   wake_lat_a: assert property ($fell(core_halted) |-> ##[0:6] isr_start) else $error("slow wake");
endmodule // cis_core_asserts
bind cis_core cis_core_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .irq_in(irq_in), .pipe(pipe),
   .isr_start(isr_start), .core_halted(core_halted), .timer_tick_en(timer_tick_en),
   .dma_enable(dma_enable), .sts_pop(sts_pop));

// ===== verif/tb.sv
// self-checking bench for the core interrupt sequencing block
`include "cis_cfg.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OP_CI = 11, OP_RTI = 10, OP_PUSH = 9, OP_IDLE = 8;
   logic aclk, aresetn, ten, isr_start, core_halted, timer_tick_en, dma_enable, sts_pop;
   logic [`CIS_NIRQ-1:0] fire_vec, irq_in, pend;
   logic [1:0] ext_src, rr, bresp, rresp;
   cis_pkg::cis_pipe_s preq, pipe;
   logic [`CIS_IDX_W-1:0] isr_vector;
   logic [31:0] awaddr, wdata, araddr, rdata, rd, mo, mm;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   int errors, check_count, cyc;
   cis_core DUT (.aclk(aclk), .aresetn(aresetn), .irq_in(irq_in), .ext_src(ext_src), .pipe(pipe),
      .isr_start(isr_start), .isr_vector(isr_vector), .core_halted(core_halted),
      .timer_tick_en(timer_tick_en), .dma_enable(dma_enable), .sts_pop(sts_pop),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   cis_far_model u_far (.aclk(aclk), .aresetn(aresetn), .fire_vec(fire_vec), .pipe_req(preq),
      .irq_in(irq_in), .pipe(pipe));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         summarize();
      end
   end
   // ****************
   // tasks and model
   // ****************
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] e);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
      @(posedge aclk);
      chk(rd, e);
   endtask
   // model: lowest pending index wins
   function automatic int top(input logic [`CIS_NIRQ-1:0] v);
      top = 0;
      for (int i = `CIS_NIRQ - 1; i >= 0; i--) if (v[i]) top = i;
   endfunction
   function automatic cis_pkg::cis_pipe_s op(input int k);
      op = cis_pkg::cis_pipe_s'(12'h001 << k);
   endfunction
   task automatic fire(input logic [`CIS_NIRQ-1:0] f, input cis_pkg::cis_pipe_s p, input bit keep);
      cis_pkg::cis_pipe_s q;
      q = p;
      q.timer_en = ten;
      if (keep) pend = pend | f;
      fire_vec <= f;
      preq <= q;
      @(posedge aclk);
      q = '0;
      q.timer_en = ten;
      fire_vec <= '0;
      preq <= q;
      @(posedge aclk);
   endtask
   task automatic return_from_interrupt();
      fire('0, op(OP_RTI), 1'b0);
   endtask
   task automatic expect_isr();
      int n;
      n = 0;
      while (isr_start !== 1'b1 && n < 40) begin
         @(posedge aclk);
         n++;
      end
      chk(isr_start, 1'b1);
      chk(isr_vector, top(pend));
      pend[top(pend)] = 1'b0;
      @(posedge aclk);
   endtask
   task automatic no_isr();
      repeat (12) begin
         @(posedge aclk);
         if (isr_start === 1'b1) chk(1'b1, 1'b0);
      end
      chk(isr_start, 1'b0);
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      aresetn = 1'b0;
      {ten, fire_vec, preq, ext_src, pend, awaddr, wdata, araddr} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {errors, check_count, cyc} = '0;
      void'($urandom(32'h6c36c131));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(`CIS_A_MODE_MASK_REGISTER, `CIS_MODE_MASK_REGISTER_RST);
      axr(8'h40, 32'h0);
      chk(rr, 2'b10);
      $display("test reset done");
      axw(`CIS_A_MASK_LO, 32'hFFFF_7FFF);
      axw(`CIS_A_MASK_HI, 32'h0000_03FF);
      fire(42'h8000, '0, 1'b1);
      no_isr();
      axr(`CIS_A_LATCH_LO, 32'h0000_8000);
      axw(`CIS_A_MASK_LO, 32'hFFFF_FFFF);
      expect_isr();
      return_from_interrupt();
      fire(42'h28, '0, 1'b1);
      expect_isr();
      axr(`CIS_A_LATCH_LO, 32'h0000_0020);
      fire(42'h8, '0, 1'b0);
      axr(`CIS_A_LATCH_LO, 32'h0000_0020);
      fire(42'h2, '0, 1'b1);
      no_isr();
      return_from_interrupt();
      expect_isr();
      return_from_interrupt();
      expect_isr();
      return_from_interrupt();
      $display("test priority done");
      axw(`CIS_A_MODE, 32'h1 << `CIS_NESTING_ENABLE_BIT_BIT);
      fire(42'h20, '0, 1'b1);
      expect_isr();
      repeat (6) @(posedge aclk);
      fire(42'h2, '0, 1'b1);
      expect_isr();
      axr(`CIS_A_PTR_LO, 32'h0000_0022);
      return_from_interrupt();
      axr(`CIS_A_PTR_LO, 32'h0000_0020);
      fire(42'h20, '0, 1'b0);
      axr(`CIS_A_LATCH_LO, 32'h0);
      fire('0, op(OP_CI), 1'b0);
      @(posedge aclk);
      chk(sts_pop, 1'b1);
      axr(`CIS_A_PTR_LO, 32'h0);
      fire(42'h20, '0, 1'b1);
      expect_isr();
      fire(42'h200, '0, 1'b1);
      no_isr();
      return_from_interrupt();
      expect_isr();
      return_from_interrupt();
      $display("test nesting done");
      repeat (4) begin
         mo = $urandom;
         mm = $urandom;
         axw(`CIS_A_MODE, mo);
         axw(`CIS_A_MODE_MASK_REGISTER, mm);
         fire('0, op(OP_PUSH), 1'b0);
         axr(`CIS_A_MODE, mo & ~mm);
      end
      for (int j = 0; j < 2; j++) begin
         axw(`CIS_A_MODE_MASK_REGISTER, `CIS_MODE_MASK_REGISTER_RST);
         axw(`CIS_A_MODE, 32'h0020_0001);
         ext_src <= 2'b10 >> j;
         fire(j ? 42'h80 : 42'h10, '0, 1'b1);
         expect_isr();
         axr(`CIS_A_MODE, 32'h0000_0001);
         return_from_interrupt();
      end
      ext_src <= 2'b00;
      axw(`CIS_A_MODE, 32'h0);
      $display("test status push done");
      ten = 1'b1;
      fire('0, op(OP_IDLE), 1'b0);
      repeat (6) @(posedge aclk);
      chk(core_halted, 1'b1);
      chk(timer_tick_en, 1'b1);
      chk(dma_enable, 1'b1);
      // halted flag plus the last serviced vector, 7
      axr(`CIS_A_STATUS, 32'h0000_0087);
      fire(42'h1000, '0, 1'b1);
      expect_isr();
      chk(core_halted, 1'b0);
      return_from_interrupt();
      $display("test idle done");
      // event lands one cycle after the interrupt line, as the latch sets and the start would be taken
      for (int k = 7; k > 0; k--) begin
         fire_vec <= 42'h4;
         pend[2] = 1'b1;
         @(posedge aclk);
         fire('0, op(k), 1'b0);
         @(posedge aclk);
         chk(isr_start, 1'b0);
         expect_isr();
         return_from_interrupt();
      end
      $display("test deferral done");
      summarize();
   end
endmodule // tb
